// file: include/uim_pkg.sv
package uim_pkg;

  // Register offsets (byte addresses)
  localparam logic [11:0] UIM_LEVEL_SEL_OFS = 12'h034;
  localparam logic [11:0] UIM_MASK_OFS      = 12'h038;
  localparam logic [11:0] UIM_RAW_OFS       = 12'h03C;
  localparam logic [11:0] UIM_MASKED_OFS    = 12'h040;
  localparam logic [11:0] UIM_CLEAR_OFS     = 12'h044;

  // Source count and bit positions
  localparam int UIM_NSRC        = 11;
  localparam int UIM_BIT_OVERRUN = 10;
  localparam int UIM_BIT_BREAK   = 9;
  localparam int UIM_BIT_PARITY  = 8;
  localparam int UIM_BIT_FRAMING = 7;
  localparam int UIM_BIT_TIMEOUT = 6;
  localparam int UIM_BIT_TX      = 5;
  localparam int UIM_BIT_RX      = 4;
  localparam int UIM_BIT_DSR     = 3;
  localparam int UIM_BIT_DCD     = 2;
  localparam int UIM_BIT_CTS     = 1;
  localparam int UIM_BIT_RING    = 0;

  // Level select field positions and reset values
  localparam int          UIM_RXSEL_LSB   = 3;
  localparam int          UIM_TXSEL_LSB   = 0;
  localparam logic [2:0]  UIM_SEL_RESET   = 3'h2;
  localparam logic [10:0] UIM_MASK_RESET  = 11'h000;
  localparam logic [10:0] UIM_STAT_RESET  = 11'h000;

  // FIFO occupancy width (32-entry FIFO, count 0..32)
  localparam int UIM_CNT_W = 6;
  localparam logic [5:0] UIM_FIFO_DEPTH = 6'h20;

  // Register bus request
  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } uim_bus_req_t;

  // Raw event inputs from the UART detectors
  typedef struct packed {
    logic overrun;
    logic brk;
    logic parity;
    logic framing;
    logic timeout;
  } uim_err_evt_t;

endpackage

// file: rtl/uim_level_cmp.sv
`timescale 1ns/1ps
module uim_level_cmp
  import uim_pkg::*;
(
  // Configuration
  input  wire logic [2:0]           sel_i,
  input  wire logic                 is_rx_i,
  // Occupancy
  input  wire logic [UIM_CNT_W-1:0] count_i,
  // Result
  output logic                      hit_o
);
  import uim_pkg::*;

  logic [UIM_CNT_W-1:0] thr;

  // Threshold in entries; rx code 001 and 010 both mean half full
  always_comb begin
    thr = UIM_FIFO_DEPTH >> 1;
    unique case (sel_i)
      3'h0: thr = UIM_FIFO_DEPTH >> 3;
      3'h1: thr = is_rx_i ? (UIM_FIFO_DEPTH >> 1) : (UIM_FIFO_DEPTH >> 2);
      3'h2: thr = UIM_FIFO_DEPTH >> 1;
      3'h3: thr = UIM_CNT_W'((UIM_FIFO_DEPTH >> 2) * 3);
      3'h4: thr = UIM_CNT_W'((UIM_FIFO_DEPTH >> 3) * 7);
      default: thr = UIM_FIFO_DEPTH >> 1; // Reserved codes act as half
    endcase
  end

  // Receive fires at or above, transmit at or below
  assign hit_o = is_rx_i ? (count_i >= thr) : (count_i <= thr);

endmodule

// file: rtl/uim_sync.sv
`timescale 1ns/1ps
module uim_sync #(
  parameter int W = 4
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  // Asynchronous levels in, synchronised levels out
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta_reg;

  // Two stages; the first is read only by the second
  // Reset to the idle high level of the active-low pins, so that the
  // change detector sees no false edge after reset
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      meta_reg <= '1;
      q_o      <= '1;
    end else begin
      meta_reg <= d_i;
      q_o      <= meta_reg;
    end
  end

endmodule

// file: rtl/uim_top.sv
// How it works
// - Mask reads back; resets zero; upper bits reserved
// - Write one sets mask, zero clears
// - Raw status shows unmasked state, read only
// - Masked status shows state after masking
// - Clear register clears written pending bits
// - Overrun 10, break 9, parity 8, framing 7
// - Timeout 6, transmit 5, receive 4
// - Dsr 3, dcd 2, cts 1, ring 0
// - Receive fires at selected fill threshold
// - Transmit fires at or below threshold
`timescale 1ns/1ps
module uim_top
  import uim_pkg::*;
(
  // Clock and reset
  input  wire logic                 CLK_I,
  input  wire logic                 RST_N_I,
  // Register port
  input  wire logic [11:0]          ADDR_I,
  input  wire logic [31:0]          WDATA_I,
  input  wire logic                 WR_I,
  input  wire logic                 RD_I,
  output logic      [31:0]          RDATA_O,
  // Line error and timeout event pulses, same clock
  input  wire uim_pkg::uim_err_evt_t ERR_EVT_I,
  // FIFO occupancy, same clock
  input  wire logic [UIM_CNT_W-1:0] RX_COUNT_I,
  input  wire logic [UIM_CNT_W-1:0] TX_COUNT_I,
  // Modem pins, active low, asynchronous
  input  wire logic                 DATA_SET_READY_IN_N_I,
  input  wire logic                 CARRIER_DETECT_IN_N_I,
  input  wire logic                 CLEAR_TO_SEND_IN_N_I,
  input  wire logic                 RING_INDICATOR_IN_N_I,
  // Interrupt outputs
  output logic [UIM_NSRC-1:0]       MASKED_IRQ_O,
  output logic                      IRQ_O
);
  import uim_pkg::*;

  uim_bus_req_t              req;
  logic [UIM_NSRC-1:0]       mask_reg;
  logic [UIM_NSRC-1:0]       raw_reg;
  logic [UIM_NSRC-1:0]       raw_next;
  logic [UIM_NSRC-1:0]       set_evt;
  logic [UIM_NSRC-1:0]       clr_vec;
  logic [UIM_NSRC-1:0]       masked;
  logic [2:0]                rx_sel_reg;
  logic [2:0]                tx_sel_reg;
  logic [3:0]                modem_sync;
  logic [3:0]                modem_prev_reg;
  logic                      modem_init_reg;
  logic                      rx_hit;
  logic                      tx_hit;
  logic                      rx_hit_prev_reg;
  logic                      tx_hit_prev_reg;
  logic [31:0]               rdata_next;

  assign req = '{addr: ADDR_I, wdata: WDATA_I, wr: WR_I, rd: RD_I};

  // Modem pins cross into this clock before anything looks at them
  uim_sync #(
    .W (4)
  ) u_sync (
    .clk_i   (CLK_I),
    .rst_n_i (RST_N_I),
    .d_i     ({DATA_SET_READY_IN_N_I, CARRIER_DETECT_IN_N_I,
               CLEAR_TO_SEND_IN_N_I, RING_INDICATOR_IN_N_I}),
    .q_o     (modem_sync)
  );

  // Receive level comparator
  uim_level_cmp u_rx_cmp (
    .sel_i   (rx_sel_reg),
    .is_rx_i (1'b1),
    .count_i (RX_COUNT_I),
    .hit_o   (rx_hit)
  );

  // Transmit level comparator
  uim_level_cmp u_tx_cmp (
    .sel_i   (tx_sel_reg),
    .is_rx_i (1'b0),
    .count_i (TX_COUNT_I),
    .hit_o   (tx_hit)
  );

  // Level compare history; edges mean a crossing happened
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      rx_hit_prev_reg <= 1'b0;
      tx_hit_prev_reg <= 1'b0;
    end else begin
      rx_hit_prev_reg <= rx_hit;
      tx_hit_prev_reg <= tx_hit;
    end
  end

  // Modem history; first sample after reset is a baseline, not a change
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      modem_prev_reg <= 4'hF;
      modem_init_reg <= 1'b0;
    end else begin
      modem_prev_reg <= modem_sync;
      modem_init_reg <= 1'b1;
    end
  end

  // Gather set events at their fixed bit positions
  always_comb begin
    set_evt                  = '0;
    set_evt[UIM_BIT_OVERRUN] = ERR_EVT_I.overrun;
    set_evt[UIM_BIT_BREAK]   = ERR_EVT_I.brk;
    set_evt[UIM_BIT_PARITY]  = ERR_EVT_I.parity;
    set_evt[UIM_BIT_FRAMING] = ERR_EVT_I.framing;
    set_evt[UIM_BIT_TIMEOUT] = ERR_EVT_I.timeout;
    set_evt[UIM_BIT_TX]      = tx_hit & ~tx_hit_prev_reg;
    set_evt[UIM_BIT_RX]      = rx_hit & ~rx_hit_prev_reg;
    set_evt[UIM_BIT_DSR]     = modem_init_reg &
                               (modem_sync[3] ^ modem_prev_reg[3]);
    set_evt[UIM_BIT_DCD]     = modem_init_reg &
                               (modem_sync[2] ^ modem_prev_reg[2]);
    set_evt[UIM_BIT_CTS]     = modem_init_reg &
                               (modem_sync[1] ^ modem_prev_reg[1]);
    set_evt[UIM_BIT_RING]    = modem_init_reg &
                               (modem_sync[0] ^ modem_prev_reg[0]);
  end

  // Clear vector: only ones written to the clear register count
  assign clr_vec = (req.wr && req.addr == UIM_CLEAR_OFS) ?
                   req.wdata[UIM_NSRC-1:0] : '0;

  // Pending state per source; a set in the clear cycle wins
  genvar g;
  generate
    for (g = 0; g < UIM_NSRC; g++) begin : g_src
      assign raw_next[g] = set_evt[g] | (raw_reg[g] & ~clr_vec[g]);
    end
  endgenerate

  // Raw pending flags
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      raw_reg <= UIM_STAT_RESET;
    end else begin
      raw_reg <= raw_next;
    end
  end

  // Mask register: each bit written directly
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      mask_reg <= UIM_MASK_RESET;
    end else if (req.wr && req.addr == UIM_MASK_OFS) begin
      mask_reg <= req.wdata[UIM_NSRC-1:0];
    end
  end

  // FIFO level select register
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      rx_sel_reg <= UIM_SEL_RESET;
      tx_sel_reg <= UIM_SEL_RESET;
    end else if (req.wr && req.addr == UIM_LEVEL_SEL_OFS) begin
      rx_sel_reg <= req.wdata[UIM_RXSEL_LSB +: 3];
      tx_sel_reg <= req.wdata[UIM_TXSEL_LSB +: 3];
    end
  end

  // Masked view and combined line
  assign masked       = raw_reg & mask_reg;
  assign MASKED_IRQ_O = masked;
  assign IRQ_O        = |masked;

  // Read mux; reserved and unmapped read as zero
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (req.rd) begin
      unique case (req.addr)
        UIM_LEVEL_SEL_OFS: rdata_next = {26'h0, rx_sel_reg, tx_sel_reg};
        UIM_MASK_OFS:      rdata_next = {21'h0, mask_reg};
        UIM_RAW_OFS:       rdata_next = {21'h0, raw_reg};
        UIM_MASKED_OFS:    rdata_next = {21'h0, masked};
        UIM_CLEAR_OFS:     rdata_next = 32'h0000_0000;
        default:           rdata_next = 32'h0000_0000;
      endcase
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      RDATA_O <= 32'h0000_0000;
    end else begin
      RDATA_O <= rdata_next;
    end
  end

endmodule

// file: bench/uim_properties.sv
`timescale 1ns/1ps
module uim_properties
  import uim_pkg::*;
(
  // Watched top ports
  input wire logic [11:0]           ADDR_I,
  input wire logic [31:0]           WDATA_I,
  input wire logic                  CLK_I,
  input wire logic                  RST_N_I,
  input wire logic                  WR_I,
  input wire logic                  RD_I,
  input wire logic [31:0]           RDATA_O,
  input wire uim_pkg::uim_err_evt_t ERR_EVT_I,
  input wire logic [UIM_NSRC-1:0]   MASKED_IRQ_O,
  input wire logic                  IRQ_O
);
  // Single domain, synchronous reset
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  // Read port stays quiet unless answering
  a_rdata_idle_zero: assert property (!RD_I |=> RDATA_O == 32'h0)
    else $error("read data not zero when idle");
  a_reserved_read_zero: assert property (RD_I |=> RDATA_O[31:11] == 21'h0)
    else $error("reserved read bits set");
  a_clear_reads_zero: assert property (
    RD_I && ADDR_I == UIM_CLEAR_OFS |=> RDATA_O == 32'h0)
    else $error("clear register read not zero");
  a_masked_read_match: assert property (
    RD_I && ADDR_I == UIM_MASKED_OFS |=> RDATA_O[10:0] == $past(MASKED_IRQ_O))
    else $error("masked read differs from masked output");
  // A zero mask bit must silence its source from the next cycle on
  a_mask_gates_irq: assert property (WR_I && ADDR_I == UIM_MASK_OFS |=>
    ({21'h0, MASKED_IRQ_O} & ~$past(WDATA_I)) == 32'h0)
    else $error("masked bit set under zero mask");
  a_irq_any_masked: assert property (IRQ_O == |MASKED_IRQ_O)
    else $error("irq level differs from masked set");
  a_overrun_clear: assert property (WR_I && ADDR_I == UIM_CLEAR_OFS &&
    WDATA_I[UIM_BIT_OVERRUN] && !ERR_EVT_I.overrun |=>
    !MASKED_IRQ_O[UIM_BIT_OVERRUN])
    else $error("overrun not cleared");
  // Pending bits are sticky: only a clear or mask write lowers them
  a_masked_sticky: assert property (!(WR_I && (ADDR_I == UIM_CLEAR_OFS ||
    ADDR_I == UIM_MASK_OFS)) |=>
    (MASKED_IRQ_O & $past(MASKED_IRQ_O)) == $past(MASKED_IRQ_O))
    else $error("masked bit fell without clear");
endmodule
bind uim_top uim_properties i_props (
  .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .CLK_I(CLK_I), .RST_N_I(RST_N_I),
  .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .ERR_EVT_I(ERR_EVT_I),
  .MASKED_IRQ_O(MASKED_IRQ_O), .IRQ_O(IRQ_O));

// file: bench/test_uart_interrupt_mask_status_clear.sv
`timescale 1ns/1ps
module test_uart_interrupt_mask_status_clear;
  import uim_pkg::*;
  logic         clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, rd_d = 1'b0;
  logic         irq;
  logic [11:0]  addr = 12'h000;
  logic [31:0]  wdata = 32'h0, rdata, m;
  logic [10:0]  mirq;
  logic [5:0]   rxc = 6'h00, txc = 6'h14;
  logic [3:0]   modem_n = 4'hF;
  logic [5:0]   rth [5] = '{6'h04, 6'h10, 6'h10, 6'h18, 6'h1C};
  logic [5:0]   tth [5] = '{6'h04, 6'h08, 6'h10, 6'h18, 6'h1C};
  logic [32:0]  exp_q [$];
  uim_err_evt_t err = '0;
  integer       seed = 32'hEC29, n_fail = 0, samples_checked = 0, i;
  always #20 clk = ~clk;
  uim_top i_dut (.CLK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr),
    .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
    .ERR_EVT_I(err), .RX_COUNT_I(rxc), .TX_COUNT_I(txc),
    .DATA_SET_READY_IN_N_I(modem_n[3]), .CARRIER_DETECT_IN_N_I(modem_n[2]),
    .CLEAR_TO_SEND_IN_N_I(modem_n[1]), .RING_INDICATOR_IN_N_I(modem_n[0]),
    .MASKED_IRQ_O(mirq), .IRQ_O(irq));
  task automatic check(input logic [32:0] seen, input logic [32:0] want);
    samples_checked++;
    if (seen !== want) begin
      n_fail++;
      $display("mismatch at %0t: got %h want %h", $time, seen, want);
    end
  endtask
  task automatic tally_and_finish;
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Strobes are left up so requests can run back to back
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    @(posedge clk);
  endtask
  task automatic rd32(input logic [11:0] a, input logic [31:0] e, input logic q);
    exp_q.push_back({q, e});
    bus(1'b0, a, 32'h0);
  endtask
  task automatic idle(input int n);
    wr <= 1'b0;
    rd <= 1'b0;
    repeat (n) @(posedge clk);
  endtask
  // Each read answer is paired with the irq level at the same cycle
  always @(posedge clk) begin
    if (rd_d) check({irq, rdata}, exp_q.pop_front());
    rd_d <= rd & rst_n;
  end
  initial begin
    #(40 * 5000);
    n_fail++;
    tally_and_finish();
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    idle(3);
    rd32(UIM_MASK_OFS, 32'h0, 1'b0);
    rd32(UIM_CLEAR_OFS, 32'h0, 1'b0);
    rd32(12'h100, 32'h0, 1'b0);
    bus(1'b1, UIM_CLEAR_OFS, 32'hFFFFFFFF);
    rd32(UIM_RAW_OFS, 32'h0, 1'b0);
    for (i = 0; i < 5; i++) begin
      m = 32'h400 >> i;
      idle(0);
      err <= uim_err_evt_t'(5'h10 >> i);
      @(posedge clk);
      err <= '0;
      bus(1'b1, UIM_MASK_OFS, m);
      rd32(UIM_RAW_OFS, m, 1'b1);
      rd32(UIM_MASKED_OFS, m, 1'b1);
      bus(1'b1, UIM_MASK_OFS, 32'h0);
      rd32(UIM_RAW_OFS, m, 1'b0);
      rd32(UIM_MASKED_OFS, 32'h0, 1'b0);
      bus(1'b1, UIM_CLEAR_OFS, m);
      rd32(UIM_RAW_OFS, 32'h0, 1'b0);
    end
    idle(0);
    err <= uim_err_evt_t'(5'h1F);
    @(posedge clk);
    err <= '0;
    for (i = 0; i < 8; i++) begin
      m = $random(seed);
      bus(1'b1, UIM_MASK_OFS, m);
      rd32(UIM_MASK_OFS, m & 32'h7FF, |(m & 32'h7C0));
      rd32(UIM_MASKED_OFS, m & 32'h7C0, |(m & 32'h7C0));
    end
    bus(1'b1, UIM_MASK_OFS, 32'h0);
    bus(1'b1, UIM_RAW_OFS, 32'hFFFFFFFF);
    bus(1'b1, UIM_CLEAR_OFS, 32'h0);
    rd32(UIM_RAW_OFS, 32'h7C0, 1'b0);
    bus(1'b1, UIM_CLEAR_OFS, 32'h7C0);
    for (i = 0; i < 5; i++) begin
      rxc <= 6'h00;
      txc <= 6'h20;
      bus(1'b1, UIM_LEVEL_SEL_OFS, (i << 3) | i);
      rxc <= rth[i] - 6'h01;
      txc <= tth[i] + 6'h01;
      idle(2);
      rd32(UIM_RAW_OFS, 32'h0, 1'b0);
      rxc <= rth[i];
      txc <= tth[i];
      idle(2);
      rd32(UIM_RAW_OFS, 32'h30, 1'b0);
      bus(1'b1, UIM_CLEAR_OFS, 32'h30);
      rd32(UIM_RAW_OFS, 32'h0, 1'b0);
    end
    for (i = 0; i < 4; i++) begin
      modem_n[i] <= ~modem_n[i];
      idle(4);
      rd32(UIM_RAW_OFS, 32'h1 << i, 1'b0);
      bus(1'b1, UIM_CLEAR_OFS, 32'h1 << i);
      rd32(UIM_RAW_OFS, 32'h0, 1'b0);
    end
    idle(0);
    err <= uim_err_evt_t'(5'h10);
    bus(1'b1, UIM_CLEAR_OFS, 32'h400);
    err <= '0;
    rd32(UIM_RAW_OFS, 32'h400, 1'b0);
    bus(1'b1, UIM_CLEAR_OFS, 32'h400);
    rd32(UIM_RAW_OFS, 32'h0, 1'b0);
    idle(3);
    tally_and_finish();
  end
endmodule
